// >>> clm_pkg.sv
// package: constants and types for the component life monitor
// Functional notes
// - at main power loss the bus capacitor discharge is timed and turned into a capacitance.
// - in factory mode the capacitor is worn out at 85% or less of the factory value.
// - in reference mode the capacitor is worn out at 85% or less of the site reference.
// - bus capacitor on-time is summed with a capacitance weight, limit 87600 h or 61320 h.
// - board capacitor on-time is summed with a temperature weight, same two limits.
// - fan run time is summed, worn out past 87600 h or 61320 h in reduced rating mode.
// - a terminal given the wear-out role goes high while any part is worn out.
// - in reference mode, unless a reference measurement is armed, no discharge timing when the load differs too much from the reference load.
// - factory mode times the discharge only when the load equals the factory load or a reference measurement is armed.
// - with the measurement enable bit clear no discharge timing is done at all.
// - a reference measurement stores the load present during it.
// - bus capacitor on-time reads back as elapsed hours and hours remaining.
// - the result reads back as a percentage of the comparison capacitance.
// - a measurement starts by itself at power loss and shows busy until done.
// - a failed reference measurement writes the failure code into both capacitance words.
// - both capacitance words at the start code arm a reference measurement.
`default_nettype none
package clm_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam logic [63:0] HOUR_CYC     = 64'(CLK_HZ) * 64'(SEC_PER_HOUR);
  localparam int unsigned DIS_TMO_MS   = 600;
  localparam logic [23:0] DIS_TMO_CYC  = 24'(CLK_HZ / 1000 * DIS_TMO_MS);
  localparam int unsigned LIFE_STD_H   = 87600;
  localparam int unsigned LIFE_ND_H    = 61320;
  localparam int unsigned W_UNIT       = 16;
  localparam logic [23:0] LIM_STD      = 24'(LIFE_STD_H * W_UNIT);
  localparam logic [23:0] LIM_ND       = 24'(LIFE_ND_H * W_UNIT);
  localparam logic [7:0]  W_NOM        = 8'(W_UNIT);
  localparam logic [7:0]  W_MID        = 8'h14;
  localparam logic [7:0]  W_HI         = 8'h18;
  localparam logic [7:0]  W_2X         = 8'h20;
  localparam logic [7:0]  W_4X         = 8'h40;
  localparam logic [7:0]  TEMP_T1      = 8'h28;
  localparam logic [7:0]  TEMP_T2      = 8'h32;
  localparam logic [15:0] PCT_FULL     = 16'h0064;
  localparam logic [15:0] PCT_EOL      = 16'h0055;
  localparam logic [15:0] PCT_95       = 16'h005f;
  localparam logic [15:0] PCT_90       = 16'h005a;
  localparam logic [15:0] CAP_START    = 16'h0000;
  localparam logic [15:0] CAP_FAIL     = 16'h0001;
  localparam logic [15:0] CAP_MIN      = 16'h0002;
  localparam logic [7:0]  FACTORY_LOAD = 8'h00;
  localparam logic [7:0]  LOAD_TOL     = 8'h08;
  localparam logic [7:0]  ROLE_LIFE    = 8'h1e;
  localparam logic [7:0]  OFF_CFG      = 8'h00;
  localparam logic [7:0]  OFF_CAP      = 8'h04;
  localparam logic [7:0]  OFF_INIT     = 8'h08;
  localparam logic [7:0]  OFF_FCAP     = 8'h0c;
  localparam logic [7:0]  OFF_ROLES    = 8'h10;
  localparam logic [7:0]  OFF_BUSH     = 8'h14;
  localparam logic [7:0]  OFF_BUSR     = 8'h18;
  localparam logic [7:0]  OFF_BRDH     = 8'h1c;
  localparam logic [7:0]  OFF_FANH     = 8'h20;
  localparam logic [7:0]  OFF_RATIO    = 8'h24;
  localparam logic [7:0]  OFF_STAT     = 8'h28;
  localparam logic [7:0]  OFF_ISTS     = 8'h2c;
  localparam logic [7:0]  OFF_IMSK     = 8'h30;
  localparam int unsigned CFG_THR_BIT  = 3;
  localparam int unsigned CFG_MEAS_BIT = 4;
  localparam int unsigned CFG_ND_BIT   = 8;
  localparam logic [31:0] CFG_MASK     = 32'h0000_0118;
  localparam logic [31:0] CFG_RST      = 32'h0000_0010;
  localparam int unsigned IRQ_DONE     = 0;
  localparam int unsigned IRQ_FAIL     = 1;
  localparam int unsigned IRQ_SKIP     = 2;
  localparam int unsigned IRQ_LIFE     = 3;
  localparam int unsigned IRQ_W        = 4;
  localparam logic [2:0]  SIZE_WORD    = 3'h2;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_MEAS = 1'b1
  } clm_st_t;
endpackage
`default_nettype wire

// >>> clm_meas_if.sv
// interface: discharge timer handshake
`timescale 1ns/100ps
`default_nettype none
interface clm_meas_if;
  logic        start;
  logic        below;
  logic        done;
  logic        fail;
  logic [15:0] value;
  modport ctrl  (output start, output below, input done, input fail, input value);
  modport timer (input start, input below, output done, output fail, output value);
endinterface
`default_nettype wire

// >>> clm_discharge_timer.sv
// module: times the bus capacitor discharge after power loss
`timescale 1ns/100ps
`default_nettype none
module clm_discharge_timer
  import clm_pkg::*;
#(
  parameter logic [23:0] TMO = DIS_TMO_CYC
) (
  input wire logic  clk,
  input wire logic  rst_n,
  clm_meas_if.timer m
);
  typedef struct packed {
    logic        run;
    logic [23:0] cnt;
    logic        done;
    logic        fail;
    logic [15:0] value;
  } clm_tmr_t;
  clm_tmr_t r_reg;
  clm_tmr_t r_next;

  // count cycles until the bus is discharged
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.fail = 1'b0;
    if (m.start) begin
      r_next.run = 1'b1;
      r_next.cnt = 24'h0;
    end else if (r_reg.run) begin
      if (m.below) begin
        r_next.run   = 1'b0;
        r_next.done  = 1'b1;
        r_next.value = r_reg.cnt[23:8]; // capacitance in 256-cycle units
        r_next.fail  = (r_reg.cnt[23:8] < CAP_MIN); // would alias the codes
      end else if (r_reg.cnt >= TMO) begin
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
        r_next.fail = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 24'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign m.done  = r_reg.done;
  assign m.fail  = r_reg.fail;
  assign m.value = r_reg.value;
endmodule // clm_discharge_timer
`default_nettype wire

// >>> clm_wear_counter.sv
// module: weighted saturating wear counter in sixteenths of an hour
`timescale 1ns/100ps
`default_nettype none
module clm_wear_counter (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [7:0]  weight,
  input  wire logic [23:0] limit,
  input  wire logic        load,
  input  wire logic [23:0] load_val,
  output logic      [23:0] acc,
  output logic             eol
);
  typedef struct packed {
    logic [23:0] acc;
  } clm_wc_t;
  clm_wc_t     r_reg;
  clm_wc_t     r_next;
  logic [24:0] sum;

  // software preload restores a saved count
  always_comb begin
    r_next = r_reg;
    sum = {1'b0, r_reg.acc} + {17'h0, weight};
    if (load) begin
      r_next.acc = load_val;
    end else if (tick && run) begin
      r_next.acc = sum[24] ? 24'hffffff : sum[23:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign acc = r_reg.acc;
  assign eol = (r_reg.acc > limit); // strictly beyond the limit
endmodule // clm_wear_counter
`default_nettype wire

// >>> clm_top.sv
// module: component life monitor with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module clm_top
  import clm_pkg::*;
#(
  parameter logic [36:0] HOUR_CYCLES = HOUR_CYC[36:0],
  parameter logic [23:0] DIS_TMO     = DIS_TMO_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        main_power_ok,
  input  wire logic        bus_voltage_on,
  input  wire logic        fan_running,
  input  wire logic        bus_discharged,
  input  wire logic [7:0]  load_level,
  input  wire logic [7:0]  ambient_temp,
  output logic             display_busy,
  output logic      [2:0]  out_terminal,
  output logic             irq
);
  typedef struct packed {
    logic [1:0]       s_main;
    logic [1:0]       s_bus;
    logic [1:0]       s_fan;
    logic [1:0]       s_dis;
    logic [7:0]       ld1;
    logic [7:0]       ld2;
    logic [7:0]       tp1;
    logic [7:0]       tp2;
    logic             main_prev;
    logic             ap_v;
    logic             ap_w;
    logic [7:0]       ap_a;
    logic [31:0]      rdata;
    logic             rdy;
    logic             resp;
    logic [31:0]      cfg;
    logic [15:0]      cap;
    logic [15:0]      init;
    logic [15:0]      fcap;
    logic [15:0]      ratio;
    logic [23:0]      roles;
    logic [7:0]       ref_load;
    logic [7:0]       meas_load;
    logic             meas_ref;
    logic             cap_eol;
    clm_st_t          st;
    logic             start;
    logic [36:0]      pre;
    logic             tick;
    logic [3:0]       life;
    logic             life_prev;
    logic [2:0]       dout;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] imsk;
    logic             irq;
    logic             busy;
  } clm_state_t;

  clm_state_t       r_reg;
  clm_state_t       r_next;
  clm_meas_if       meas ();
  logic [23:0]      acc_bus;
  logic [23:0]      acc_brd;
  logic [23:0]      acc_fan;
  logic             eol_bus;
  logic             eol_brd;
  logic             eol_fan;
  logic [23:0]      limit;
  logic [19:0]      lim_h;
  logic [19:0]      remain;
  logic [15:0]      ref_cap;
  logic [7:0]       w_bus;
  logic [7:0]       w_brd;
  logic [7:0]       load_diff;
  logic             load_ok;
  logic             wr;
  logic             ld_bus;
  logic             ld_brd;
  logic             ld_fan;
  logic [23:0]      ld_val;
  logic             pdown;
  logic             accept;
  logic [31:0]      rd;
  logic [31:0]      pct;
  logic [31:0]      prod_ref;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [2:0]       dout_nx;

  ////////////////////////////////////////////////////////////////////////////
  // wear counters and discharge timer

  clm_wear_counter u_bus (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (r_reg.tick),
    .run      (r_reg.s_bus[1]),
    .weight   (w_bus),
    .limit    (limit),
    .load     (ld_bus),
    .load_val (ld_val),
    .acc      (acc_bus),
    .eol      (eol_bus)
  );

  clm_wear_counter u_brd (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (r_reg.tick),
    .run      (r_reg.s_bus[1]),
    .weight   (w_brd),
    .limit    (limit),
    .load     (ld_brd),
    .load_val (ld_val),
    .acc      (acc_brd),
    .eol      (eol_brd)
  );

  clm_wear_counter u_fan (
    .clk      (hclk),
    .rst_n    (hresetn),
    .tick     (r_reg.tick),
    .run      (r_reg.s_fan[1]),
    .weight   (W_NOM),
    .limit    (limit),
    .load     (ld_fan),
    .load_val (ld_val),
    .acc      (acc_fan),
    .eol      (eol_fan)
  );

  clm_discharge_timer #(
    .TMO (DIS_TMO)
  ) u_tmr (
    .clk   (hclk),
    .rst_n (hresetn),
    .m     (meas.timer)
  );

  assign meas.start = r_reg.start;
  assign meas.below = r_reg.s_dis[1];

  ////////////////////////////////////////////////////////////////////////////
  // derived terms

  // reduced rating mode shortens every life limit
  assign limit  = r_reg.cfg[CFG_ND_BIT] ? LIM_ND : LIM_STD;
  assign lim_h  = limit[23:4];
  assign remain = (lim_h > acc_bus[23:4]) ? (lim_h - acc_bus[23:4]) : 20'h0;

  // lower capacitance ages the capacitor faster
  assign w_bus = (r_reg.ratio >= PCT_95) ? W_NOM :
                 (r_reg.ratio >= PCT_90) ? W_MID : W_HI;
  // doubles per ten degrees above nominal ambient
  assign w_brd = (r_reg.tp2 <= TEMP_T1) ? W_NOM :
                 (r_reg.tp2 <= TEMP_T2) ? W_2X : W_4X;

  // comparison base follows the threshold selection bit
  assign ref_cap = r_reg.cfg[CFG_THR_BIT] ? r_reg.init : r_reg.fcap;

  assign load_diff = (r_reg.ld2 > r_reg.ref_load) ? (r_reg.ld2 - r_reg.ref_load)
                                                  : (r_reg.ref_load - r_reg.ld2);
  // factory mode needs the exact load, reference mode a near match
  assign load_ok = r_reg.cfg[CFG_THR_BIT] ? (load_diff <= LOAD_TOL)
                                          : (r_reg.ld2 == FACTORY_LOAD);

  assign pdown  = r_reg.main_prev && !r_reg.s_main[1];
  assign accept = hsel && hready && htrans[1] && (hsize == SIZE_WORD);
  assign wr     = r_reg.ap_v && r_reg.ap_w;
  assign ld_bus = wr && (r_reg.ap_a == OFF_BUSH);
  assign ld_brd = wr && (r_reg.ap_a == OFF_BRDH);
  assign ld_fan = wr && (r_reg.ap_a == OFF_FANH);
  assign ld_val = {hwdata[19:0], 4'h0};
  assign clr    = (wr && (r_reg.ap_a == OFF_ISTS)) ? hwdata[IRQ_W-1:0] : '0;

  // result as percent of the base, guarded against code values
  assign pct      = (ref_cap >= CAP_MIN) ?
                    ((32'(meas.value) * 32'(PCT_FULL)) / {16'h0, ref_cap}) : 32'(PCT_FULL);
  assign prod_ref = 32'(ref_cap) * 32'(PCT_EOL);

  // one terminal per role word
  generate
    for (genvar i = 0; i < 3; i++) begin : g_term
      assign dout_nx[i] = (r_reg.roles[i*8 +: 8] == ROLE_LIFE) && (|r_reg.life);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, sampled in the address phase

  always_comb begin
    case (haddr[7:0])
      OFF_CFG:   rd = r_reg.cfg;
      OFF_CAP:   rd = {16'h0, r_reg.cap};
      OFF_INIT:  rd = {16'h0, r_reg.init};
      OFF_FCAP:  rd = {16'h0, r_reg.fcap};
      OFF_ROLES: rd = {8'h0, r_reg.roles};
      OFF_BUSH:  rd = {12'h0, acc_bus[23:4]};
      OFF_BUSR:  rd = {12'h0, remain};
      OFF_BRDH:  rd = {12'h0, acc_brd[23:4]};
      OFF_FANH:  rd = {12'h0, acc_fan[23:4]};
      OFF_RATIO: rd = {16'h0, r_reg.ratio};
      OFF_STAT:  rd = {16'h0, r_reg.ref_load, 3'h0, r_reg.busy, r_reg.life};
      OFF_ISTS:  rd = {28'h0, r_reg.ists};
      OFF_IMSK:  rd = {28'h0, r_reg.imsk};
      default:   rd = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_next = r_reg;
    ev = '0;
    // pin synchronisers, first stage feeds only the second
    r_next.s_main = {r_reg.s_main[0], main_power_ok};
    r_next.s_bus  = {r_reg.s_bus[0], bus_voltage_on};
    r_next.s_fan  = {r_reg.s_fan[0], fan_running};
    r_next.s_dis  = {r_reg.s_dis[0], bus_discharged};
    r_next.ld1 = load_level;
    r_next.ld2 = r_reg.ld1;
    r_next.tp1 = ambient_temp;
    r_next.tp2 = r_reg.tp1;
    r_next.main_prev = r_reg.s_main[1];

    // hour prescaler
    r_next.tick = 1'b0;
    if (r_reg.pre >= HOUR_CYCLES - 37'h1) begin
      r_next.pre  = 37'h0;
      r_next.tick = 1'b1;
    end else begin
      r_next.pre = r_reg.pre + 37'h1;
    end

    // zero-wait slave: read data is ready in the data phase
    r_next.ap_v = accept;
    r_next.ap_w = hwrite;
    r_next.ap_a = haddr[7:0];
    if (accept && !hwrite) begin
      r_next.rdata = rd;
    end
    r_next.rdy  = 1'b1;
    r_next.resp = 1'b0;

    // register writes in the data phase
    if (wr) begin
      case (r_reg.ap_a)
        OFF_CFG:   r_next.cfg   = hwdata & CFG_MASK;
        OFF_CAP:   r_next.cap   = hwdata[15:0];
        OFF_INIT:  r_next.init  = hwdata[15:0];
        OFF_FCAP:  r_next.fcap  = hwdata[15:0];
        OFF_ROLES: r_next.roles = hwdata[23:0];
        OFF_IMSK:  r_next.imsk  = hwdata[IRQ_W-1:0];
        default:   r_next.roles = r_reg.roles;
      endcase
    end

    // measurement sequencer; power loss alone never clears stored values
    r_next.start = 1'b0;
    case (r_reg.st)
      ST_IDLE: begin
        if (pdown) begin
          if (!r_reg.cfg[CFG_MEAS_BIT]) begin
            ev[IRQ_SKIP] = 1'b1;
          end else if (r_reg.cap == CAP_START && r_reg.init == CAP_START) begin
            r_next.start     = 1'b1;
            r_next.meas_ref  = 1'b1;
            r_next.meas_load = r_reg.ld2;
            r_next.st        = ST_MEAS;
          end else if (load_ok) begin
            r_next.start    = 1'b1;
            r_next.meas_ref = 1'b0;
            r_next.st       = ST_MEAS;
          end else begin
            ev[IRQ_SKIP] = 1'b1;
          end
        end
      end
      ST_MEAS: begin
        if (meas.done) begin
          r_next.st = ST_IDLE;
          if (r_reg.meas_ref) begin
            if (meas.fail) begin
              r_next.cap  = CAP_FAIL;
              r_next.init = CAP_FAIL;
              ev[IRQ_FAIL] = 1'b1;
            end else begin
              r_next.cap      = meas.value;
              r_next.init     = meas.value;
              r_next.ref_load = r_reg.meas_load;
              r_next.ratio    = PCT_FULL;
              r_next.cap_eol  = 1'b0;
              ev[IRQ_DONE] = 1'b1;
            end
          end else if (meas.fail) begin
            ev[IRQ_FAIL] = 1'b1;
          end else begin
            r_next.cap   = meas.value;
            r_next.ratio = (|pct[31:16]) ? 16'hffff : pct[15:0];
            // at or below 85 percent of the chosen base
            r_next.cap_eol = (32'(meas.value) * 32'(PCT_FULL)) <= prod_ref;
            ev[IRQ_DONE] = 1'b1;
          end
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    r_next.busy = (r_next.st == ST_MEAS);

    // life summary and warning terminals
    r_next.life = {eol_fan, eol_brd, eol_bus, r_reg.cap_eol};
    r_next.life_prev = |r_reg.life;
    if ((|r_reg.life) && !r_reg.life_prev) begin
      ev[IRQ_LIFE] = 1'b1;
    end
    r_next.dout = dout_nx;

    // sticky status: an event in the clearing cycle wins
    r_next.ists = (r_reg.ists & ~clr) | ev;
    r_next.irq  = |(r_next.ists & r_next.imsk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg       <= '0;
      r_reg.cfg   <= CFG_RST;
      r_reg.ratio <= PCT_FULL;
      r_reg.rdy   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout    = r_reg.rdy;
  assign hresp        = r_reg.resp;
  assign hrdata       = r_reg.rdata;
  assign display_busy = r_reg.busy;
  assign out_terminal = r_reg.dout;
  assign irq          = r_reg.irq;
endmodule // clm_top
`default_nettype wire

// >>> clm_power_stage.sv
// model: power stage that drops the mains and lets the bus decay
`timescale 1ns/100ps
`default_nettype none
module clm_power_stage (
  input  wire logic        hclk,
  input  wire logic        power_cut,
  input  wire logic [15:0] hold_cyc,
  output logic             main_power_ok,
  output logic             bus_voltage_on,
  output logic             bus_discharged
);
  logic [15:0] dis_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // decay timer runs with mains off, parks at the hold figure
  always_ff @(posedge hclk) begin
    if (!power_cut) begin
      dis_cnt <= 16'h0;
    end else if (dis_cnt != hold_cyc) begin
      dis_cnt <= dis_cnt + 16'h1;
    end
  end
  // a discharged bus no longer powers the on-time counters
  assign main_power_ok  = !power_cut;
  assign bus_discharged = power_cut && (dis_cnt == hold_cyc);
  assign bus_voltage_on = !bus_discharged;
endmodule // clm_power_stage
`default_nettype wire

// >>> clm_checker.sv
// checker: port-level properties of the life monitor
`timescale 1ns/100ps
`default_nettype none
module clm_checker
  import clm_pkg::*;
#(
  parameter logic [36:0] HOUR_CYCLES = 37'h10,
  parameter logic [23:0] DIS_TMO     = 24'h7d0
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        main_power_ok,
  input wire logic        bus_discharged,
  input wire logic        display_busy,
  input wire logic [2:0]  out_terminal,
  input wire logic        irq
);
  logic        wr_tk;
  logic        rd_tk;
  logic [23:0] busy_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // accepted word transfers
  assign wr_tk = hsel && hready && htrans[1] && hwrite && (hsize == SIZE_WORD);
  assign rd_tk = hsel && hready && htrans[1] && !hwrite && (hsize == SIZE_WORD);
  // busy length, catches a timer that never ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt <= 24'h0;
    end else begin
      busy_cnt <= display_busy ? busy_cnt + 24'h1 : 24'h0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence dis_held;
    (display_busy && bus_discharged) ##1 bus_discharged [*3];
  endsequence
  reset_quiet_a: assert property ($rose(hresetn) |-> !display_busy && !irq && !out_terminal)
    else $error("outputs not idle after reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  read_hold_a: assert property (!rd_tk |=> $stable(hrdata))
    else $error("read data moved without a read");
  busy_rise_a: assert property ($rose(display_busy) |-> !$past(main_power_ok, 3))
    else $error("busy rose without a power loss");
  single_meas_a: assert property ((!main_power_ok) [*8] |-> !$rose(display_busy))
    else $error("second measurement in one shutdown");
  busy_end_a: assert property (dis_held |-> ##[0:3] !display_busy)
    else $error("busy outlived the discharge");
  busy_bound_a: assert property (busy_cnt <= DIS_TMO + 24'h8)
    else $error("measurement ran past its timeout");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_tk, 2) || $past(wr_tk, 3))
    else $error("interrupt dropped without a write");
endmodule // clm_checker
bind clm_top clm_checker #(.HOUR_CYCLES(HOUR_CYCLES), .DIS_TMO(DIS_TMO)) clm_checker_inst (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp, .hrdata,
  .main_power_ok, .bus_discharged, .display_busy, .out_terminal, .irq);
`default_nettype wire

// >>> component_life_monitor_bench.sv
// bench: drives the life monitor over ahb-lite beside a power stage model
`timescale 1ns/100ps
`default_nettype none
module component_life_monitor_bench
  import clm_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic        fan_running = 1'b0;
  logic        power_cut = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = SIZE_WORD;
  logic [7:0]  load_level = 8'h00;
  logic [7:0]  ambient_temp = 8'h19;
  logic [15:0] hold_cyc = 16'h0032;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hreadyout, hresp, irq, display_busy;
  logic        main_power_ok, bus_voltage_on, bus_discharged;
  logic [2:0]  out_terminal;
  logic [31:0] hrdata;
  int          err_total = 0;
  int          n_compared = 0;
  ////////////////////////////////////////////////////////////////////////////
  // short hour and timeout for a brief run
  clm_top #(.HOUR_CYCLES(37'h10), .DIS_TMO(24'h1770)) clm_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .main_power_ok, .bus_voltage_on, .fan_running,
    .bus_discharged, .load_level, .ambient_temp, .display_busy, .out_terminal, .irq);
  clm_power_stage clm_power_stage_inst (
    .hclk, .power_cut, .hold_cyc, .main_power_ok, .bus_voltage_on, .bus_discharged);
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task results;
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // each phase waits for hreadyout, which this zero-wait slave holds high
  task rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q & m, e);
  endtask
  // mains off until the bus decays and busy ends
  task pwr(input logic [15:0] hold, input logic busy_exp, input logic back);
    hold_cyc <= hold;
    power_cut <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({31'h0, display_busy}, {31'h0, busy_exp});
    while (display_busy !== 1'b0 || bus_discharged !== 1'b1) @(posedge hclk);
    power_cut <= !back;
    repeat (8) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_bus;
    rd(OFF_CFG, 32'hffffffff, CFG_RST);
    hsize <= 3'h1;
    wr(OFF_CFG, 32'h0);
    hsize <= SIZE_WORD;
    rd(OFF_CFG, 32'hffffffff, CFG_RST);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'hffffffff, 32'h0);
    wr(OFF_IMSK, 32'hf);
  endtask
  task t_ref;
    load_level <= 8'h21;
    pwr(16'h04b0, 1'b1, 1'b1);
    rd(OFF_CAP, 32'hffff, 32'h4);
    rd(OFF_INIT, 32'hffff, 32'h4);
    rd(OFF_RATIO, 32'hffff, 32'h64);
    rd(OFF_STAT, 32'hff00, 32'h2100);
    rd(OFF_ISTS, 32'hf, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_ISTS, 32'hf);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task t_site;
    wr(OFF_CFG, 32'h18);
    wr(OFF_ROLES, 32'h1e);
    load_level <= 8'h27;
    pwr(16'h0320, 1'b1, 1'b1);
    rd(OFF_CAP, 32'hffff, 32'h3);
    rd(OFF_RATIO, 32'hffff, 32'h4b);
    rd(OFF_STAT, 32'h1, 32'h1);
    rd(OFF_ISTS, 32'hf, 32'h9);
    chk({29'h0, out_terminal}, 32'h1);
  endtask
  // first base stays above 85 percent, second lands on it
  task t_factory;
    wr(OFF_CFG, 32'h10);
    load_level <= FACTORY_LOAD;
    for (int i = 0; i < 2; i++) begin
      wr(OFF_FCAP, 32'h13 + 32'(i));
      pwr(16'h1130, 1'b1, 1'b1);
      rd(OFF_CAP, 32'hffff, 32'h11);
      rd(OFF_RATIO, 32'hffff, i ? 32'h55 : 32'h59);
      rd(OFF_STAT, 32'h1, 32'(i));
    end
  endtask
  task t_skip;
    logic [31:0] cf [3];
    logic [7:0]  ld [3];
    cf = '{32'h0, 32'h10, 32'h18};
    ld = '{8'h00, 8'h01, 8'h30};
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CFG, cf[i]);
      load_level <= ld[i];
      wr(OFF_ISTS, 32'hf);
      pwr(16'h0032, 1'b0, 1'b1);
      rd(OFF_ISTS, 32'h7, 32'h4);
      rd(OFF_CAP, 32'hffff, 32'h11);
    end
  endtask
  // mains off so on-time counters stand still
  task t_count;
    wr(OFF_CFG, 32'h0);
    pwr(16'h0032, 1'b0, 1'b0);
    wr(OFF_BUSH, 32'h3e8);
    rd(OFF_BUSH, 32'hfffff, 32'h3e8);
    rd(OFF_BUSR, 32'hfffff, 32'(LIFE_STD_H - 32'h3e8));
    wr(OFF_CFG, 32'h100);
    rd(OFF_BUSR, 32'hfffff, 32'(LIFE_ND_H - 32'h3e8));
    wr(OFF_FANH, 32'(LIFE_ND_H));
    @(posedge hclk);
    rd(OFF_STAT, 32'h8, 32'h0);
    wr(OFF_FANH, 32'(LIFE_ND_H + 32'h1));
    wr(OFF_BRDH, 32'(LIFE_ND_H + 32'h1));
    wr(OFF_BUSH, 32'(LIFE_ND_H + 32'h1));
    wr(OFF_ROLES, 32'h1e001e);
    rd(OFF_STAT, 32'he, 32'he);
    chk({29'h0, out_terminal}, 32'h5);
    wr(OFF_CFG, 32'h0);
    @(posedge hclk);
    rd(OFF_STAT, 32'he, 32'h0);
    wr(OFF_FANH, 32'hfffff);
    fan_running <= 1'b1;
    repeat (64) @(posedge hclk);
    fan_running <= 1'b0;
    rd(OFF_FANH, 32'hfffff, 32'hfffff);
    power_cut <= 1'b0;
  endtask
  task t_fail;
    wr(OFF_CFG, 32'h10);
    wr(OFF_CAP, 32'h0);
    wr(OFF_INIT, 32'h0);
    pwr(16'h1b58, 1'b1, 1'b1);
    rd(OFF_CAP, 32'hffff, 32'(CAP_FAIL));
    rd(OFF_INIT, 32'hffff, 32'(CAP_FAIL));
    rd(OFF_ISTS, 32'h2, 32'h2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_bus();
    t_ref();
    t_site();
    t_factory();
    t_skip();
    t_count();
    t_fail();
    results();
  end
  // watchdog past the longest run
  initial begin
    repeat (60000) @(posedge hclk);
    err_total++;
    results();
  end
endmodule // component_life_monitor_bench
`default_nettype wire
